// [logic/cacp_top.sv]
// Clock alarm / status pin configuration bank with its pin steering.
// Assumes a byte-wide synchronous register port from the serial host
// interface and raw detector inputs synchronous to MCLK.
`timescale 1ns/1ps
module cacp_top
    import cacp_pkg::*;
#(
    parameter logic [31:0] VAL0_CYC   = 32'(CACP_VAL0_CYC),
    parameter logic [31:0] VAL1_CYC   = 32'(CACP_VAL1_CYC),
    parameter logic [31:0] VAL2_CYC   = 32'(CACP_VAL2_CYC),
    parameter logic [31:0] VAL3_CYC   = 32'(CACP_VAL3_CYC),
    parameter logic [31:0] LOCKT0_CYC = 32'(CACP_LOCKT0_CYC)
)
(
    input  wire logic       MCLK,
    input  wire logic       RESET_N,
    // Register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    // Configuration held elsewhere in the device
    input  wire logic [1:0] AUTOMATIC_SELECT_MODE,
    input  wire logic [1:0] MANUAL_INPUT_SELECT_FIELD,
    input  wire logic       LOCK_LOSS_PIN_POLARITY,
    input  wire logic       INPUT1_LOSS_INTERRUPT_MASK,
    input  wire logic [1:0] OFFSET_ALARM_PER_INPUT_ENABLE,
    // Detector and status inputs
    input  wire logic [1:0] OFFSET_EXCEEDED,
    input  wire logic       INPUT1_SIGNAL_LOSS,
    input  wire logic       INPUT2_BAD_STATUS,
    input  wire logic       OTHER_INTERRUPT,
    input  wire logic       PHASE_SLIP,
    input  wire logic       INPUT1_ACTIVE_STATUS,
    // Outputs to the analog front end and selection logic
    output logic            INPUT1_BUFFER_OFF,
    output logic            INPUT2_BUFFER_OFF,
    output logic      [1:0] OFFSET_ALARM_THRESHOLD,
    output logic     [11:0] OFFSET_THRESHOLD_DPPM,
    output logic      [1:0] FREQUENCY_OFFSET_ALARM,
    output logic            LOCK_LOSS_STATUS,
    output logic      [1:0] SELECTED_INPUT,
    // Pins: output value and active-low output enable, plus the select/active shared pin's input value
    output logic            INPUT2_BAD_OUTPUT,
    output logic            INPUT2_BAD_OUTPUT_OE_N,
    output logic            SHARED_ALARM_OUTPUT,
    output logic            SHARED_ALARM_OUTPUT_OE_N,
    output logic            LOCK_LOSS_OUTPUT,
    output logic            LOCK_LOSS_OUTPUT_OE_N,
    output logic            SELECT_ACTIVE_SHARED_PIN_O,
    output logic            SELECT_ACTIVE_SHARED_PIN_OE_N,
    input  wire logic       SELECT_ACTIVE_SHARED_PIN_I
);
    typedef struct packed
    {
        logic [7:0]  pwdn;
        logic [7:0]  timing;
        logic [7:0]  pins;
        logic [7:0]  selpin;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [31:0] lock_cnt;
        logic        lock_loss_output;
        logic        pd1;
        logic        pd2;
        logic [1:0]  thr;
        logic [11:0] thr_dppm;
        logic [1:0]  frequency_offset_alarm;
        logic [1:0]  sel;
        logic        c2b;
        logic        c2b_oe_n;
        logic        shared;
        logic        shared_oe_n;
        logic        lolo;
        logic        lolo_oe_n;
        logic        ca;
        logic        ca_oe_n;
    } cacp_state_t;

    cacp_state_t r;
    cacp_state_t next_r;
    logic [1:0]  fos_alarm;
    logic [1:0]  raw_fos;

    // Masked write keeps reserved bits at reset value
    function automatic logic [7:0] cacp_merge(input logic [7:0] old_v,
                                              input logic [7:0] wr_v,
                                              input logic [7:0] mask);
        cacp_merge = (old_v & ~mask) | (wr_v & mask);
    endfunction : cacp_merge

    // Lock one-shot interval: halves per code step
    function automatic logic [31:0] cacp_lock_oneshot_interval(input logic [2:0] code,
                                               input logic [31:0] base);
        cacp_lock_oneshot_interval = base >> code;
    endfunction : cacp_lock_oneshot_interval

    // Offset alarm only counts when enabled globally and per input
    always_comb
    begin
        raw_fos = OFFSET_EXCEEDED & OFFSET_ALARM_PER_INPUT_ENABLE
                  & {2{r.timing[CACP_BIT_OFFSET_ALARM_GLOBAL_ENABLE]}};
    end

    // One validator per input delays the alarm clear
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_val
            cacp_validator #(
                .VAL0 (VAL0_CYC),
                .VAL1 (VAL1_CYC),
                .VAL2 (VAL2_CYC),
                .VAL3 (VAL3_CYC)
            ) u_val (
                .clk     (MCLK),
                .reset_n (RESET_N),
                .alarm_clear_validation_time (r.timing[CACP_POS_VAL +: 2]),
                .raw_bad (raw_fos[gi]),
                .alarm   (fos_alarm[gi])
            );
        end
    endgenerate

    always_comb
    begin
        logic        lol_now;
        logic        intr;
        logic        shared_val;
        logic        manual;
        next_r = r;
        lol_now    = 1'b0;
        intr       = 1'b0;
        shared_val = 1'b0;
        manual     = 1'b0;

        // Register writes; reserved bits never change
        if (REG_WR)
        begin
            case (REG_ADDR)
                CACP_ADDR_PWDN:
                    next_r.pwdn = cacp_merge(r.pwdn, REG_WDATA, CACP_WMASK_PWDN);
                CACP_ADDR_TIMING:
                    next_r.timing = cacp_merge(r.timing, REG_WDATA, CACP_WMASK_TIMING);
                CACP_ADDR_PINS:
                    next_r.pins = cacp_merge(r.pins, REG_WDATA, CACP_WMASK_PINS);
                CACP_ADDR_SELPIN:
                    next_r.selpin = cacp_merge(r.selpin, REG_WDATA, CACP_WMASK_SELPIN);
                default:
                    next_r.pwdn = r.pwdn;
            endcase
        end

        // Reads answer one cycle later; unmapped reads return zero
        next_r.rvalid = REG_RD;
        if (REG_RD)
        begin
            case (REG_ADDR)
                CACP_ADDR_PWDN:   next_r.rdata = r.pwdn;
                CACP_ADDR_TIMING: next_r.rdata = r.timing;
                CACP_ADDR_PINS:   next_r.rdata = r.pins;
                CACP_ADDR_SELPIN: next_r.rdata = r.selpin;
                default:          next_r.rdata = 8'h00;
            endcase
        end

        // Input buffer power-downs
        next_r.pd1 = r.pwdn[CACP_BIT_PD1];
        next_r.pd2 = r.pwdn[CACP_BIT_PD2];

        // Threshold code and its level in tenths of ppm
        next_r.thr = r.timing[CACP_POS_THR +: 2];
        case (r.timing[CACP_POS_THR +: 2])
            2'h0:    next_r.thr_dppm = CACP_THR0_DPPM;
            2'h1:    next_r.thr_dppm = CACP_THR1_DPPM;
            2'h2:    next_r.thr_dppm = CACP_THR2_DPPM;
            default: next_r.thr_dppm = CACP_THR3_DPPM;
        endcase
        next_r.frequency_offset_alarm = fos_alarm;

        // Lock one-shot: each slip retriggers, expiry clears lock loss
        if (PHASE_SLIP)
        begin
            next_r.lock_cnt = cacp_lock_oneshot_interval(r.timing[CACP_POS_LOCK_ONESHOT_INTERVAL +: 3], LOCKT0_CYC);
            lol_now = 1'b1;
        end
        else if (r.lock_cnt != 32'h0)
        begin
            next_r.lock_cnt = r.lock_cnt - 32'h1;
            lol_now = 1'b1;
        end
        next_r.lock_loss_output = lol_now;

        // Second-input bad pin
        next_r.c2b      = INPUT2_BAD_STATUS;
        next_r.c2b_oe_n = ~r.pins[CACP_BIT_IN2PIN];

        // Shared alarm pin: interrupt or input1 bad
        intr = (INPUT1_SIGNAL_LOSS & ~INPUT1_LOSS_INTERRUPT_MASK) | OTHER_INTERRUPT;
        if (r.pins[CACP_BIT_INTPIN])
            shared_val = intr;
        else
            shared_val = INPUT1_SIGNAL_LOSS;
        next_r.shared      = shared_val;
        next_r.shared_oe_n = ~r.pins[CACP_BIT_SHAREDPIN];

        // Lock-loss pin with programmable polarity
        next_r.lolo      = lol_now ~^ LOCK_LOSS_PIN_POLARITY;
        next_r.lolo_oe_n = ~r.pins[CACP_BIT_LOLPIN];

        // Input selection; pin source honoured only in manual mode
        manual = (AUTOMATIC_SELECT_MODE == CACP_AUTOSEL_MANUAL);
        if (manual && r.selpin[CACP_BIT_SELSRC])
            next_r.sel = {1'b0, SELECT_ACTIVE_SHARED_PIN_I};
        else
            next_r.sel = MANUAL_INPUT_SELECT_FIELD;

        // Shared pin drives active status only when not an input
        next_r.ca = INPUT1_ACTIVE_STATUS;
        next_r.ca_oe_n = ~(r.selpin[CACP_BIT_ACTPIN]
                           & ~(manual & r.selpin[CACP_BIT_SELSRC]));
    end

    // Single state register
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            r             <= '0;
            r.pwdn        <= CACP_RST_PWDN;
            r.timing      <= CACP_RST_TIMING;
            r.pins        <= CACP_RST_PINS;
            r.selpin      <= CACP_RST_SELPIN;
            r.c2b_oe_n    <= 1'b1;
            r.shared_oe_n <= 1'b1;
            r.lolo_oe_n   <= 1'b1;
            r.ca_oe_n     <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign REG_RDATA                     = r.rdata;
    assign REG_RVALID                    = r.rvalid;
    assign INPUT1_BUFFER_OFF             = r.pd1;
    assign INPUT2_BUFFER_OFF             = r.pd2;
    assign OFFSET_ALARM_THRESHOLD        = r.thr;
    assign OFFSET_THRESHOLD_DPPM         = r.thr_dppm;
    assign FREQUENCY_OFFSET_ALARM        = r.frequency_offset_alarm;
    assign LOCK_LOSS_STATUS              = r.lock_loss_output;
    assign SELECTED_INPUT                = r.sel;
    assign INPUT2_BAD_OUTPUT             = r.c2b;
    assign INPUT2_BAD_OUTPUT_OE_N        = r.c2b_oe_n;
    assign SHARED_ALARM_OUTPUT           = r.shared;
    assign SHARED_ALARM_OUTPUT_OE_N      = r.shared_oe_n;
    assign LOCK_LOSS_OUTPUT              = r.lolo;
    assign LOCK_LOSS_OUTPUT_OE_N         = r.lolo_oe_n;
    assign SELECT_ACTIVE_SHARED_PIN_O    = r.ca;
    assign SELECT_ACTIVE_SHARED_PIN_OE_N = r.ca_oe_n;

endmodule : cacp_top

// [inc/cacp_pkg.sv]
// Constants, register map and types for the clock alarm/pin configuration bank.
// Assumes a byte-wide host register port and a single 100 MHz clock.
package cacp_pkg;

    localparam logic [7:0] CACP_ADDR_PWDN   = 8'h0B;
    localparam logic [7:0] CACP_ADDR_TIMING = 8'h13;
    localparam logic [7:0] CACP_ADDR_PINS   = 8'h14;
    localparam logic [7:0] CACP_ADDR_SELPIN = 8'h15;

    localparam logic [7:0] CACP_RST_PWDN   = 8'h40;
    localparam logic [7:0] CACP_RST_TIMING = 8'h2C;
    localparam logic [7:0] CACP_RST_PINS   = 8'h3E;
    localparam logic [7:0] CACP_RST_SELPIN = 8'hFF;

    // Writable bit masks; other bits hold their reset value
    localparam logic [7:0] CACP_WMASK_PWDN   = 8'h03;
    localparam logic [7:0] CACP_WMASK_TIMING = 8'hFF;
    localparam logic [7:0] CACP_WMASK_PINS   = 8'h0F;
    localparam logic [7:0] CACP_WMASK_SELPIN = 8'h03;

    // Field positions
    localparam int CACP_BIT_PD1       = 0;
    localparam int CACP_BIT_PD2       = 1;
    localparam int CACP_BIT_OFFSET_ALARM_GLOBAL_ENABLE    = 7;
    localparam int CACP_POS_THR       = 5;
    localparam int CACP_POS_VAL       = 3;
    localparam int CACP_POS_LOCK_ONESHOT_INTERVAL     = 0;
    localparam int CACP_BIT_INTPIN    = 0;
    localparam int CACP_BIT_LOLPIN    = 1;
    localparam int CACP_BIT_SHAREDPIN = 2;
    localparam int CACP_BIT_IN2PIN    = 3;
    localparam int CACP_BIT_SELSRC    = 0;
    localparam int CACP_BIT_ACTPIN    = 1;

    // Times in their own units, and derived cycle counts at 100 MHz
    localparam longint CACP_CLK_HZ       = 100000000;
    localparam longint CACP_VAL0_US      = 2000;
    localparam longint CACP_VAL1_US      = 100000;
    localparam longint CACP_VAL2_US      = 200000;
    localparam longint CACP_VAL3_US      = 13000000;
    localparam longint CACP_LOCKT0_NS    = 106000000;
    localparam longint CACP_LOCKT7_NS    = 833000;
    localparam longint CACP_VAL0_CYC     = CACP_VAL0_US * (CACP_CLK_HZ / 1000000);
    localparam longint CACP_VAL1_CYC     = CACP_VAL1_US * (CACP_CLK_HZ / 1000000);
    localparam longint CACP_VAL2_CYC     = CACP_VAL2_US * (CACP_CLK_HZ / 1000000);
    localparam longint CACP_VAL3_CYC     = CACP_VAL3_US * (CACP_CLK_HZ / 1000000);
    localparam longint CACP_LOCKT0_CYC   = CACP_LOCKT0_NS / (1000000000 / CACP_CLK_HZ);

    // Threshold codes in tenths of ppm (upper bound of each band)
    localparam logic [11:0] CACP_THR0_DPPM = 12'h078;
    localparam logic [11:0] CACP_THR1_DPPM = 12'h1EA;
    localparam logic [11:0] CACP_THR2_DPPM = 12'h12C;
    localparam logic [11:0] CACP_THR3_DPPM = 12'h7D0;

    localparam logic [1:0] CACP_AUTOSEL_MANUAL = 2'h0;

    typedef enum logic [2:0]
    {
        CACP_V_IDLE  = 3'b001,
        CACP_V_COUNT = 3'b010,
        CACP_V_CLEAR = 3'b100
    } cacp_vstate_t;

endpackage : cacp_pkg

// [logic/cacp_validator.sv]
// Alarm-clear validator for one input: holds the alarm until the clock
// has been good for the programmed validation time.
// Assumes the raw bad indication is synchronous to the clock.
`timescale 1ns/1ps
module cacp_validator
    import cacp_pkg::*;
#(
    parameter logic [31:0] VAL0 = 32'(CACP_VAL0_CYC),
    parameter logic [31:0] VAL1 = 32'(CACP_VAL1_CYC),
    parameter logic [31:0] VAL2 = 32'(CACP_VAL2_CYC),
    parameter logic [31:0] VAL3 = 32'(CACP_VAL3_CYC)
)
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [1:0] alarm_clear_validation_time,
    input  wire logic       raw_bad,
    output logic            alarm
);
    typedef struct packed
    {
        cacp_vstate_t st;
        logic [31:0]  cnt;
        logic         alarm;
    } cacp_vreg_t;

    cacp_vreg_t r;
    cacp_vreg_t next_r;
    logic [31:0] limit;

    // Validation window length per code
    always_comb
    begin
        case (alarm_clear_validation_time)
            2'h0:    limit = VAL0;
            2'h1:    limit = VAL1;
            2'h2:    limit = VAL2;
            default: limit = VAL3;
        endcase
    end

    // A bad sample restarts the window, except in the clear cycle; alarm rises at once
    always_comb
    begin
        next_r = r;
        case (r.st)
            CACP_V_IDLE:
            begin
                if (raw_bad)
                begin
                    next_r.alarm = 1'b1;
                    next_r.cnt   = 32'h0;
                    next_r.st    = CACP_V_COUNT;
                end
            end
            CACP_V_COUNT:
            begin
                if (raw_bad)
                    next_r.cnt = 32'h0;
                else if (r.cnt + 32'h1 >= limit)
                    next_r.st = CACP_V_CLEAR;
                else
                    next_r.cnt = r.cnt + 32'h1;
            end
            CACP_V_CLEAR:
            begin
                next_r.alarm = 1'b0;
                next_r.cnt   = 32'h0;
                next_r.st    = CACP_V_IDLE;
            end
            default:
                next_r.st = CACP_V_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            r <= '{st: CACP_V_IDLE, cnt: 32'h0, alarm: 1'b0};
        else
            r <= next_r;
    end

    assign alarm = r.alarm;

endmodule : cacp_validator

// [dv/cacp_assertions.sv]
// Checker for the pin steering and register port of the config bank.
// Assumes it is bound into cacp_top and sees only that module's ports.
`timescale 1ns/1ps
module cacp_assertions
    import cacp_pkg::*;
#(
    parameter logic [31:0] LOCKT0_CYC = 32'd128
)
(
    input wire logic       MCLK,
    input wire logic       RESET_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic       REG_RVALID,
    input wire logic [1:0] AUTOMATIC_SELECT_MODE,
    input wire logic       LOCK_LOSS_PIN_POLARITY,
    input wire logic       INPUT1_LOSS_INTERRUPT_MASK,
    input wire logic       INPUT1_SIGNAL_LOSS,
    input wire logic       INPUT2_BAD_STATUS,
    input wire logic       OTHER_INTERRUPT,
    input wire logic       PHASE_SLIP,
    input wire logic       LOCK_LOSS_STATUS,
    input wire logic       INPUT2_BAD_OUTPUT,
    input wire logic       INPUT2_BAD_OUTPUT_OE_N,
    input wire logic       SHARED_ALARM_OUTPUT,
    input wire logic       SHARED_ALARM_OUTPUT_OE_N,
    input wire logic       LOCK_LOSS_OUTPUT,
    input wire logic       LOCK_LOSS_OUTPUT_OE_N,
    input wire logic       SELECT_ACTIVE_SHARED_PIN_OE_N
);
    logic [7:0] s14;
    logic [7:0] s15;
    logic [1:0] age;
    logic [8:0] since;
    logic       ok;
    logic       mapped;

    // Shadow of the pin registers; pins lag a write by two edges
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N)
        begin
            s14 <= CACP_RST_PINS;
            s15 <= CACP_RST_SELPIN;
            age <= 2'h0;
        end
        else
        begin
            if (REG_WR && REG_ADDR == 8'h14)
                s14 <= REG_WDATA;
            if (REG_WR && REG_ADDR == 8'h15)
                s15 <= REG_WDATA;
            if (age != 2'h3)
                age <= age + 2'h1;
        end
    end

    // Cycles since the last slip, saturating so it never wraps
    always_ff @(posedge MCLK)
    begin
        if (!RESET_N || PHASE_SLIP)
            since <= PHASE_SLIP ? 9'h000 : 9'h1FF;
        else if (since != 9'h1FF)
            since <= since + 9'h001;
    end

    assign ok = (age == 2'h3);
    assign mapped = REG_ADDR inside {8'h0B, 8'h13, 8'h14, 8'h15};

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence slip_s;
        PHASE_SLIP;
    endsequence

    AST_RVALID: assert property (1'b1 |=> REG_RVALID == $past(REG_RD))
        else $error("read valid not one cycle after read");
    AST_UNMAPPED_ZERO: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_IN2_OE: assert property (ok |-> INPUT2_BAD_OUTPUT_OE_N == !$past(s14[3]))
        else $error("input2 bad pin enable wrong");
    AST_IN2_VAL: assert property (ok && !INPUT2_BAD_OUTPUT_OE_N |->
        INPUT2_BAD_OUTPUT == $past(INPUT2_BAD_STATUS)) else $error("input2 bad pin value wrong");
    AST_SHARED_OE: assert property (ok |-> SHARED_ALARM_OUTPUT_OE_N == !$past(s14[2]))
        else $error("shared alarm pin enable wrong");
    AST_SHARED_VAL: assert property (ok && !SHARED_ALARM_OUTPUT_OE_N |->
        SHARED_ALARM_OUTPUT == ($past(s14[0]) ? $past((INPUT1_SIGNAL_LOSS &&
        !INPUT1_LOSS_INTERRUPT_MASK) || OTHER_INTERRUPT) : $past(INPUT1_SIGNAL_LOSS)))
        else $error("shared alarm pin value wrong");
    AST_LOL_OE: assert property (ok |-> LOCK_LOSS_OUTPUT_OE_N == !$past(s14[1]))
        else $error("lock loss pin enable wrong");
    AST_LOL_VAL: assert property (ok && !LOCK_LOSS_OUTPUT_OE_N |->
        LOCK_LOSS_OUTPUT == (LOCK_LOSS_STATUS ~^ $past(LOCK_LOSS_PIN_POLARITY)))
        else $error("lock loss pin value wrong");
    AST_SEL_OE: assert property (ok |-> SELECT_ACTIVE_SHARED_PIN_OE_N ==
        !($past(s15[1]) && !($past(AUTOMATIC_SELECT_MODE) == 2'h0 && $past(s15[0]))))
        else $error("select pin enable wrong");
    AST_SLIP_SET: assert property (slip_s |=> LOCK_LOSS_STATUS)
        else $error("slip did not start one-shot");
    AST_SLIP_CAUSE: assert property ($rose(LOCK_LOSS_STATUS) |-> $past(PHASE_SLIP))
        else $error("one-shot rose without slip");
    AST_SLIP_END: assert property (since > LOCKT0_CYC + 32'd4 |-> !LOCK_LOSS_STATUS)
        else $error("one-shot outlived its interval");
endmodule : cacp_assertions

bind cacp_top cacp_assertions #(.LOCKT0_CYC(LOCKT0_CYC)) u_chk (.*);

// [dv/tb_cacp_top.sv]
// Self-checking bench: register port, pin steering, one-shot, alarms.
// Assumes cacp_top with shortened counts and the checker bound to it.
`timescale 1ns/1ps
module tb_cacp_top;
    import cacp_pkg::*;
    logic MCLK, RESET_N, REG_WR, REG_RD, REG_RVALID, LOCK_LOSS_PIN_POLARITY;
    logic INPUT1_LOSS_INTERRUPT_MASK, INPUT1_SIGNAL_LOSS, INPUT2_BAD_STATUS;
    logic OTHER_INTERRUPT, PHASE_SLIP, INPUT1_ACTIVE_STATUS, SELECT_ACTIVE_SHARED_PIN_I;
    logic INPUT1_BUFFER_OFF, INPUT2_BUFFER_OFF, LOCK_LOSS_STATUS, INPUT2_BAD_OUTPUT;
    logic INPUT2_BAD_OUTPUT_OE_N, SHARED_ALARM_OUTPUT, SHARED_ALARM_OUTPUT_OE_N;
    logic LOCK_LOSS_OUTPUT, LOCK_LOSS_OUTPUT_OE_N, SELECT_ACTIVE_SHARED_PIN_O;
    logic SELECT_ACTIVE_SHARED_PIN_OE_N;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic [1:0] AUTOMATIC_SELECT_MODE, MANUAL_INPUT_SELECT_FIELD, OFFSET_ALARM_PER_INPUT_ENABLE;
    logic [1:0] OFFSET_EXCEEDED, OFFSET_ALARM_THRESHOLD, FREQUENCY_OFFSET_ALARM, SELECTED_INPUT;
    logic [11:0] OFFSET_THRESHOLD_DPPM;
    localparam logic [7:0] ATAB [6] = '{8'h0B, 8'h13, 8'h14, 8'h15, 8'h00, 8'h16};
    localparam logic [7:0] MSK [4] = '{8'h03, 8'hFF, 8'h0F, 8'h03};
    localparam logic [7:0] RST [4] = '{8'h40, 8'h2C, 8'h3E, 8'hFF};
    localparam logic [11:0] THR [4] = '{12'd120, 12'd490, 12'd300, 12'd2000};
    localparam int VAL [4] = '{10, 20, 30, 40};
    logic [7:0] mdl [4];
    logic [31:0] r;
    integer seed = 57;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int d;

    // Short counts keep the run brief; expectations use the same figures
    cacp_top #(.VAL0_CYC(32'd10), .VAL1_CYC(32'd20), .VAL2_CYC(32'd30), .VAL3_CYC(32'd40),
        .LOCKT0_CYC(32'd128)) DUT (.*);

    // 100 MHz clock
    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // Hang guard: far above the under a thousand cycles the tests need
    always @(posedge MCLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : tick

    function automatic logic [7:0] mread(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < 4; i++)
            if (ATAB[i] == a)
                v = mdl[i];
        return v;
    endfunction : mread

    // One write strobe; the model keeps reserved bits at reset value
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        tick(1);
        REG_ADDR = a;
        REG_WDATA = dat;
        REG_WR = 1'b1;
        for (int i = 0; i < 4; i++)
            if (ATAB[i] == a)
                mdl[i] = (RST[i] & ~MSK[i]) | (dat & MSK[i]);
        tick(1);
        REG_WR = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        tick(1);
        REG_ADDR = a;
        REG_RD = 1'b1;
        tick(1);
        REG_RD = 1'b0;
        chk(REG_RVALID, 1);
        chk(REG_RDATA, mread(a));
    endtask : rd

    initial
    begin
        {RESET_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA, PHASE_SLIP} = '0;
        {AUTOMATIC_SELECT_MODE, MANUAL_INPUT_SELECT_FIELD, OFFSET_EXCEEDED} = '0;
        {LOCK_LOSS_PIN_POLARITY, INPUT1_LOSS_INTERRUPT_MASK, INPUT1_SIGNAL_LOSS} = '0;
        {INPUT2_BAD_STATUS, OTHER_INTERRUPT, INPUT1_ACTIVE_STATUS} = '0;
        {SELECT_ACTIVE_SHARED_PIN_I, OFFSET_ALARM_PER_INPUT_ENABLE} = '0;
        for (int i = 0; i < 4; i++)
            mdl[i] = RST[i];
        repeat (4) @(posedge MCLK);
        #1;
        RESET_N = 1'b1;
        for (int i = 0; i < 6; i++)
            rd(ATAB[i]);
        $display("test reset_values done");
        // Random writes, unmapped places among them, each read back
        repeat (24)
        begin
            r = $random(seed);
            wr(ATAB[r[2:0] % 6], r[15:8]);
            rd(ATAB[r[2:0] % 6]);
        end
        for (int c = 0; c < 4; c++)
        begin
            r = $random(seed);
            wr(8'h0B, {r[5:0], 2'(c)});
            wr(8'h13, {r[7], 2'(c), r[4:0]});
            tick(2);
            chk(INPUT1_BUFFER_OFF, c % 2);
            chk(INPUT2_BUFFER_OFF, c / 2);
            chk(OFFSET_ALARM_THRESHOLD, c);
            chk(OFFSET_THRESHOLD_DPPM, THR[c]);
        end
        $display("test registers done");
        // Every pin enable combination with random status levels
        for (int p = 0; p < 16; p++)
        begin
            r = $random(seed);
            wr(8'h14, {r[11:8], 4'(p)});
            {INPUT2_BAD_STATUS, INPUT1_SIGNAL_LOSS, INPUT1_LOSS_INTERRUPT_MASK} = r[2:0];
            {OTHER_INTERRUPT, LOCK_LOSS_PIN_POLARITY} = r[4:3];
            tick(3);
            chk(INPUT2_BAD_OUTPUT_OE_N, !p[3]);
            chk(SHARED_ALARM_OUTPUT_OE_N, !p[2]);
            chk(LOCK_LOSS_OUTPUT_OE_N, !p[1]);
            if (p[3])
                chk(INPUT2_BAD_OUTPUT, r[2]);
            if (p[2])
                chk(SHARED_ALARM_OUTPUT, p[0] ? (r[1] & ~r[0]) | r[4] : r[1]);
            if (p[1])
                chk(LOCK_LOSS_OUTPUT, !r[3]);
            rd(8'h14);
        end
        $display("test pins done");
        // One-shot length halves with each interval code
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h13, 8'(c));
            tick(2);
            PHASE_SLIP = 1'b1;
            tick(1);
            PHASE_SLIP = 1'b0;
            chk(LOCK_LOSS_OUTPUT, LOCK_LOSS_PIN_POLARITY);
            d = 0;
            while (LOCK_LOSS_STATUS === 1'b1 && d < 400)
            begin
                d++;
                tick(1);
            end
            chk(d >= (128 >> c) && d <= (128 >> c) + 2, 1);
        end
        $display("test lock_oneshot done");
        // Selection source across all modes; only manual honours it
        for (int s = 0; s < 4; s++)
        begin
            wr(8'h15, 8'(s));
            for (int m = 0; m < 4; m++)
            begin
                r = $random(seed);
                AUTOMATIC_SELECT_MODE = 2'(m);
                {MANUAL_INPUT_SELECT_FIELD, SELECT_ACTIVE_SHARED_PIN_I} = r[2:0];
                INPUT1_ACTIVE_STATUS = r[3];
                tick(3);
                chk(SELECT_ACTIVE_SHARED_PIN_OE_N, !(s[1] && !(m == 0 && s[0])));
                if (!SELECT_ACTIVE_SHARED_PIN_OE_N)
                    chk(SELECT_ACTIVE_SHARED_PIN_O, r[3]);
                if (m == 0)
                    chk(SELECTED_INPUT, s[0] ? {1'b0, r[0]} : r[2:1]);
                else
                    chk(SELECTED_INPUT, r[2:1]);
            end
        end
        $display("test selection done");
        // Alarm clears only after the validation time; input 2 disabled
        OFFSET_ALARM_PER_INPUT_ENABLE = 2'b01;
        for (int v = 0; v < 4; v++)
        begin
            wr(8'h13, {1'b1, 2'b00, 2'(v), 3'h0});
            tick(2);
            OFFSET_EXCEEDED = 2'b11;
            tick(3);
            chk(FREQUENCY_OFFSET_ALARM, 2'b01);
            OFFSET_EXCEEDED = 2'b00;
            d = 0;
            while (FREQUENCY_OFFSET_ALARM[0] === 1'b1 && d < 200)
            begin
                d++;
                tick(1);
            end
            chk(d >= VAL[v] && d <= VAL[v] + 4, 1);
        end
        wr(8'h13, 8'h00);
        OFFSET_EXCEEDED = 2'b11;
        tick(4);
        chk(FREQUENCY_OFFSET_ALARM, 2'b00);
        $display("test offset_alarm done");
        complete_run();
    end
endmodule : tb_cacp_top
